// ### rom_io_pkg.sv
// shared constants and types for the multiplexed-bus rom with i/o port
package rom_io_pkg;
  // ---------------------------------------------------------------
  // clocking of the processor side
  // ---------------------------------------------------------------
  localparam int CLK_HZ = 20000000;
  localparam int PERIOD_NS = 400;
  localparam int PERIOD_CLKS = PERIOD_NS / (1000000000 / CLK_HZ);
  localparam logic [2:0] TICK_LAST = 3'(PERIOD_CLKS - 1);
  localparam logic [2:0] PHI1_RISE_TICK = 3'h0;
  localparam logic [2:0] PHI1_FALL_TICK = 3'h2;
  localparam logic [2:0] PHI2_RISE_TICK = 3'h4;
  localparam logic [2:0] PHI2_FALL_TICK = 3'h6;
  localparam logic [2:0] SAMPLE_TICK = 3'h7;
  // ---------------------------------------------------------------
  // bus periods of one instruction cycle
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    addr_low,
    addr_high,
    addr_chip,
    first_data_period,
    second_data_period,
    exec_first,
    exec_second,
    exec_third
  } period_t;
  // ---------------------------------------------------------------
  // instruction codes seen on the bus
  // ---------------------------------------------------------------
  localparam logic [3:0] OPR_SEND_REG = 4'h2;
  localparam logic [3:0] OPR_IO = 4'he;
  localparam logic [3:0] OPA_PORT_WRITE = 4'h2;
  localparam logic [3:0] OPA_PORT_READ = 4'ha;
  localparam logic [3:0] OPA_SEND_REG = 4'h1;
  localparam logic [3:0] BUS_IDLE = 4'hf;
  // ---------------------------------------------------------------
  // controller registers on wishbone
  // ---------------------------------------------------------------
  localparam logic [3:0] CMD_OFS = 4'h0;
  localparam logic [3:0] STATUS_OFS = 4'h4;
  localparam int CMD_ADDR_POS = 0;
  localparam int CMD_CHIP_POS = 8;
  localparam int CMD_DATA_POS = 12;
  localparam int CMD_KIND_POS = 16;
  localparam int STAT_BUSY_POS = 0;
  localparam int STAT_WORD_POS = 8;
  localparam int STAT_PORT_POS = 16;
  localparam logic [17:0] CMD_RESET = 18'h0;
  typedef enum logic [1:0] {
    kind_fetch,
    kind_send_reg,
    kind_port_write,
    kind_port_read
  } cmd_kind_t;
endpackage : rom_io_pkg

// ### bus_link_if.sv
// shared 4-line bus, clock phases, cycle marker and bank line between the two ends
interface bus_link_if;
  logic phi1;
  logic phi2;
  logic sync;
  logic bank_command_line;
  logic [3:0] host_dout;
  logic host_oe;
  logic [3:0] dev_dout;
  logic dev_oe;
  wire [3:0] data;
  // undriven lines float high
  assign data = dev_oe ? dev_dout : (host_oe ? host_dout : rom_io_pkg::BUS_IDLE);
  modport host (
    output phi1,
    output phi2,
    output sync,
    output bank_command_line,
    output host_dout,
    output host_oe,
    input data
  );
  modport device (
    input phi1,
    input phi2,
    input sync,
    input bank_command_line,
    output dev_dout,
    output dev_oe,
    input data
  );
endinterface : bus_link_if

// ### rom_io_device.sv
// rom with 4-bit i/o port, device end of the multiplexed bus
// Notes on behaviour
// (RL1) array holds 256 bytes, byte address selects
// (RL2) all traffic over four shared bus lines
// (RL3) timing from two phases and cycle marker
// (RL4) three address nibbles captured after marker
// (RL5) respond only when chip nibble matches
// (RL6) chip number fixed at build time
// (RL7) bank line selects group; others silent
// (RL8) word driven in two data periods
// (RL9) port moves data between bus, pins
// (RL10) execute only own port instructions
// (RL11) decode port read versus port write
// (RL12) clear input empties output register immediately
// (RL13) pin direction fixed per pin
// (RL14) pin polarity fixed per pin
// (RL15) output register holds until write/clear
// (RL16) bus undriven unless driving data
//
// Local design decisions: register access over Wishbone and the address map.
module rom_io_device #(
  parameter logic [3:0] CHIP_ID = 4'h0,
  parameter logic [3:0] PIN_IS_OUTPUT = 4'h0,
  parameter logic [3:0] PIN_INVERT = 4'h0,
  parameter logic [2047:0] ROM_IMAGE = '0
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  bus_link_if.device link,
  input wire logic port_clear_in,
  input wire logic [3:0] port_pin_in,
  output logic [3:0] port_pin_out,
  output logic [3:0] port_pin_oe_out
);
  import rom_io_pkg::*;

  // ---------------------------------------------------------------
  // mask-programmed array
  // ---------------------------------------------------------------
  logic [7:0] rom_mem [256];
  genvar gi;
  generate
    for (gi = 0; gi < 256; gi++) begin : g_rom
      assign rom_mem[gi] = ROM_IMAGE[gi*8 +: 8]; // see (RL1)
    end
  endgenerate

  // ---------------------------------------------------------------
  // input synchronisers
  // ---------------------------------------------------------------
  // all pins cross together so phases, marker and data stay aligned
  logic [12:0] raw_in;
  logic [12:0] meta_r;
  logic [12:0] samp_r;
  assign raw_in = {port_pin_in, link.data, port_clear_in, link.bank_command_line,
                   link.sync, link.phi2, link.phi1};
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      meta_r <= '0;
      samp_r <= '0;
    end else begin
      meta_r <= raw_in;
      samp_r <= meta_r;
    end
  end

  wire phi1_s = samp_r[0];
  wire phi2_s = samp_r[1];
  wire sync_s = samp_r[2];
  wire bank_s = samp_r[3];
  wire clear_s = samp_r[4];
  wire [3:0] bus_s = samp_r[8:5];
  wire [3:0] pins_s = samp_r[12:9];

  // ---------------------------------------------------------------
  // phase edges
  // ---------------------------------------------------------------
  logic phi1_d_r;
  logic phi2_d_r;
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      phi1_d_r <= 1'b0;
      phi2_d_r <= 1'b0;
    end else begin
      phi1_d_r <= phi1_s;
      phi2_d_r <= phi2_s;
    end
  end
  // no oscillator here: the period advances only on processor phases
  wire phi1_rise = phi1_s & ~phi1_d_r; // see (RL3)
  wire phi2_rise = phi2_s & ~phi2_d_r; // see (RL3)

  // ---------------------------------------------------------------
  // period tracking
  // ---------------------------------------------------------------
  period_t per_r;
  logic marker_seen_r;
  period_t per_nxt;
  assign per_nxt = marker_seen_r ? addr_low : period_t'(3'(per_r + 3'h1)); // see (RL3)

  // ---------------------------------------------------------------
  // captured address and instruction
  // ---------------------------------------------------------------
  logic [7:0] addr_r;
  logic rom_sel_r;
  logic [3:0] opr_r;
  logic port_sel_r;
  logic port_wr_r;
  logic port_rd_r;
  logic [3:0] out_reg_r;
  logic [3:0] dout_r;
  logic oe_r;

  wire chip_match = (bus_s == CHIP_ID); // see (RL5) (RL6)
  wire is_port_op = (opr_r == OPR_IO) && bank_s; // see (RL10)
  wire is_port_wr = is_port_op && (bus_s == OPA_PORT_WRITE) && port_sel_r; // see (RL11)
  wire is_port_rd = is_port_op && (bus_s == OPA_PORT_READ) && port_sel_r; // see (RL11)

  // ---------------------------------------------------------------
  // port pins
  // ---------------------------------------------------------------
  // read side passes input pins only; output pins read back as zero
  wire [3:0] pins_true = (pins_s ^ PIN_INVERT) & ~PIN_IS_OUTPUT; // see (RL13) (RL14)
  // the raw clear pin gates the pins directly so the effect needs no phase
  wire [3:0] out_shown = port_clear_in ? 4'h0 : out_reg_r; // see (RL12)

  assign port_pin_out = (out_shown ^ PIN_INVERT) & PIN_IS_OUTPUT; // see (RL14) (RL15)
  assign port_pin_oe_out = PIN_IS_OUTPUT; // see (RL13)

  // ---------------------------------------------------------------
  // drive selection for the coming period
  // ---------------------------------------------------------------
  logic drive_nxt;
  logic [3:0] dout_nxt;
  wire [7:0] word = rom_mem[addr_r];
  always_comb begin
    drive_nxt = 1'b0;
    dout_nxt = 4'h0;
    unique case (per_nxt)
      first_data_period: begin
        drive_nxt = rom_sel_r; // see (RL8)
        dout_nxt = word[7:4];
      end
      second_data_period: begin
        drive_nxt = rom_sel_r; // see (RL8)
        dout_nxt = word[3:0];
      end
      exec_second: begin
        drive_nxt = port_rd_r; // see (RL9)
        dout_nxt = pins_true;
      end
      addr_low, addr_high, addr_chip, exec_first, exec_third: begin
        drive_nxt = 1'b0; // see (RL16)
        dout_nxt = 4'h0;
      end
    endcase
  end

  assign link.dev_oe = oe_r; // see (RL2) (RL16)
  assign link.dev_dout = dout_r;

  // ---------------------------------------------------------------
  // sequencing
  // ---------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      per_r <= exec_third;
      marker_seen_r <= 1'b0;
      oe_r <= 1'b0;
      dout_r <= 4'h0;
    end else if (phi1_rise) begin
      per_r <= per_nxt;
      oe_r <= drive_nxt;
      dout_r <= dout_nxt;
    end else if (phi2_rise) begin
      marker_seen_r <= sync_s;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      addr_r <= 8'h00;
      rom_sel_r <= 1'b0;
      opr_r <= 4'h0;
      port_sel_r <= 1'b0;
      port_wr_r <= 1'b0;
      port_rd_r <= 1'b0;
    end else if (phi2_rise) begin
      unique case (per_r)
        addr_low: addr_r[3:0] <= bus_s; // see (RL4)
        addr_high: addr_r[7:4] <= bus_s; // see (RL4)
        addr_chip: rom_sel_r <= chip_match && bank_s; // see (RL4) (RL5) (RL7)
        first_data_period: opr_r <= bus_s;
        second_data_period: begin
          port_wr_r <= is_port_wr;
          port_rd_r <= is_port_rd;
          rom_sel_r <= 1'b0;
        end
        exec_second: begin
          // a send-register cycle with the bank line up picks the port chip
          if (opr_r == OPR_SEND_REG && bank_s) begin
            port_sel_r <= chip_match; // see (RL10) (RL7)
          end
        end
        exec_third: begin
          port_wr_r <= 1'b0;
          port_rd_r <= 1'b0;
        end
        exec_first: opr_r <= opr_r;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // output register
  // ---------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      out_reg_r <= 4'h0;
    end else if (clear_s || port_clear_in) begin
      out_reg_r <= 4'h0; // see (RL12)
    end else if (phi2_rise && per_r == exec_second && port_wr_r) begin
      out_reg_r <= bus_s; // see (RL9) (RL15)
    end
  end

endmodule : rom_io_device

// ### rom_io_host.sv
// processor end of the multiplexed bus, ordered over classic wishbone
module rom_io_host (
  input wire logic clk_in,
  input wire logic rst_n_in,
  bus_link_if.host link,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [3:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out
);
  import rom_io_pkg::*;

  // ---------------------------------------------------------------
  // phase generator
  // ---------------------------------------------------------------
  logic [2:0] tick_r;
  period_t per_r;
  logic phi1_r;
  logic phi2_r;
  logic sync_r;
  wire end_of_period = (tick_r == TICK_LAST);
  wire [2:0] tick_nxt = end_of_period ? 3'h0 : 3'(tick_r + 3'h1);
  period_t per_nxt;
  assign per_nxt = end_of_period ? period_t'(3'(per_r + 3'h1)) : per_r;

  // ---------------------------------------------------------------
  // command registers
  // ---------------------------------------------------------------
  logic [17:0] cmd_r;
  logic go_r;
  logic busy_r;
  logic [7:0] word_r;
  logic [3:0] port_r;
  logic ack_r;
  wire wb_req = wb_cyc_in && wb_stb_in && !ack_r;
  wire cmd_hit = wb_req && wb_we_in && (wb_adr_in == CMD_OFS) && (&wb_sel_in[2:0]) && !go_r && !busy_r;
  wire [7:0] c_addr = cmd_r[CMD_ADDR_POS +: 8];
  wire [3:0] c_chip = cmd_r[CMD_CHIP_POS +: 4];
  wire [3:0] c_data = cmd_r[CMD_DATA_POS +: 4];
  cmd_kind_t c_kind;
  assign c_kind = cmd_kind_t'(cmd_r[CMD_KIND_POS +: 2]);
  wire [31:0] status_word = {12'h0, port_r, word_r, 7'h0, busy_r | go_r};
  wire [31:0] rd_mux = (wb_adr_in == CMD_OFS) ? {14'h0, cmd_r} :
                       (wb_adr_in == STATUS_OFS) ? status_word : 32'h0;

  // ---------------------------------------------------------------
  // bus drive for the coming period
  // ---------------------------------------------------------------
  logic oe_nxt;
  logic [3:0] dout_nxt;
  logic bank_nxt;
  wire act_nxt = busy_r || (go_r && per_nxt == addr_low);
  always_comb begin
    oe_nxt = 1'b0;
    dout_nxt = 4'h0;
    bank_nxt = 1'b0;
    unique case (per_nxt)
      addr_low: begin
        oe_nxt = act_nxt;
        dout_nxt = c_addr[3:0]; // see (RL4)
      end
      addr_high: begin
        oe_nxt = act_nxt;
        dout_nxt = c_addr[7:4];
      end
      addr_chip: begin
        oe_nxt = act_nxt;
        dout_nxt = c_chip;
        bank_nxt = act_nxt && c_kind == kind_fetch; // see (RL7)
      end
      first_data_period: begin
        oe_nxt = act_nxt && c_kind != kind_fetch;
        dout_nxt = (c_kind == kind_send_reg) ? OPR_SEND_REG : OPR_IO;
      end
      second_data_period: begin
        oe_nxt = act_nxt && c_kind != kind_fetch;
        dout_nxt = (c_kind == kind_send_reg) ? OPA_SEND_REG :
                   (c_kind == kind_port_write) ? OPA_PORT_WRITE : OPA_PORT_READ;
        bank_nxt = act_nxt && (c_kind == kind_port_write || c_kind == kind_port_read);
      end
      exec_second: begin
        oe_nxt = act_nxt && (c_kind == kind_send_reg || c_kind == kind_port_write);
        dout_nxt = (c_kind == kind_send_reg) ? c_chip : c_data;
        bank_nxt = act_nxt && c_kind == kind_send_reg;
      end
      exec_third: begin
        oe_nxt = act_nxt && c_kind == kind_send_reg;
        dout_nxt = 4'h0;
      end
      exec_first: begin
        oe_nxt = 1'b0;
        dout_nxt = 4'h0;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // sequencing
  // ---------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      // restart on the last tick so the first phase pulses and marker come out whole
      tick_r <= TICK_LAST;
      per_r <= exec_second;
      phi1_r <= 1'b0;
      phi2_r <= 1'b0;
      sync_r <= 1'b0;
    end else begin
      tick_r <= tick_nxt;
      per_r <= per_nxt;
      phi1_r <= (tick_nxt >= PHI1_RISE_TICK) && (tick_nxt < PHI1_FALL_TICK); // see (RL3)
      phi2_r <= (tick_nxt >= PHI2_RISE_TICK) && (tick_nxt < PHI2_FALL_TICK);
      sync_r <= (per_nxt == exec_third); // see (RL3) (RL4)
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      link.host_oe <= 1'b0;
      link.host_dout <= 4'h0;
      link.bank_command_line <= 1'b0;
      busy_r <= 1'b0;
    end else if (end_of_period) begin
      link.host_oe <= oe_nxt; // see (RL2)
      link.host_dout <= dout_nxt;
      link.bank_command_line <= bank_nxt;
      busy_r <= act_nxt && per_nxt != exec_third ? 1'b1 : (per_nxt == exec_third ? busy_r : 1'b0);
      if (per_r == exec_third) begin
        busy_r <= go_r;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      cmd_r <= CMD_RESET;
      go_r <= 1'b0;
      word_r <= 8'h00;
      port_r <= 4'h0;
      ack_r <= 1'b0;
      wb_dat_out <= 32'h0;
    end else begin
      ack_r <= wb_req;
      if (wb_req) begin
        wb_dat_out <= rd_mux;
      end
      if (cmd_hit) begin
        cmd_r <= wb_dat_in[17:0];
        go_r <= 1'b1;
      end else if (end_of_period && per_r == exec_third) begin
        go_r <= 1'b0;
      end
      if (busy_r && tick_r == SAMPLE_TICK) begin
        if (per_r == first_data_period && c_kind == kind_fetch) begin
          word_r[7:4] <= link.data;
        end
        if (per_r == second_data_period && c_kind == kind_fetch) begin
          word_r[3:0] <= link.data;
        end
        if (per_r == exec_second && c_kind == kind_port_read) begin
          port_r <= link.data;
        end
      end
    end
  end

  assign wb_ack_out = ack_r;
  assign link.phi1 = phi1_r;
  assign link.phi2 = phi2_r;
  assign link.sync = sync_r;

endmodule : rom_io_host

// ### rom_io_chk.sv
// checker watching the shared four-line bus between the host and device ends
module rom_io_chk #(
  parameter logic [3:0] CHIP_ID = 4'h0,
  parameter logic [2047:0] ROM_IMAGE = '0
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic phi1,
  input wire logic phi2,
  input wire logic sync,
  input wire logic bank_command_line,
  input wire logic [3:0] host_dout,
  input wire logic host_oe,
  input wire logic [3:0] dev_dout,
  input wire logic dev_oe,
  input wire logic [3:0] data
);
  // ---------------------------------------------------------------
  // tick within the instruction cycle, zero at the first addr_low tick
  // ---------------------------------------------------------------
  logic [6:0] tick_r;
  logic [6:0] tick_nxt;
  logic [7:0] addr_r;
  logic sel_r;
  wire [7:0] exp_byte;
  assign tick_nxt = sync ? 7'h00 : tick_r + 7'h01;
  assign exp_byte = ROM_IMAGE[{addr_r, 3'h0} +: 8];
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      tick_r <= 7'h00;
    end else begin
      tick_r <= tick_nxt;
    end
  end
  // sample late in each address period, well clear of the drive change at tick 0
  always_ff @(posedge clk_in) begin
    if (tick_r == 7'h06) addr_r[3:0] <= data;
    if (tick_r == 7'h0e) addr_r[7:4] <= data;
    if (tick_r == 7'h16) sel_r <= (data == CHIP_ID) && bank_command_line;
  end
  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking @(posedge clk_in);
  endclocking
  default disable iff (!rst_n_in);
  property p_phase_excl;
    !(phi1 && phi2);
  endproperty
  a_phase_excl: assert property (p_phase_excl) else $error("phases overlap");
  property p_phi_spacing;
    $rose(phi1) |-> ##1 phi1 ##1 !phi1 ##2 $rose(phi2);
  endproperty
  a_phi_spacing: assert property (p_phi_spacing) else $error("phase spacing wrong");
  property p_phi_period;
    $rose(phi1) |-> ##8 $rose(phi1);
  endproperty
  a_phi_period: assert property (p_phi_period) else $error("period not 8 clocks");
  property p_sync_len;
    $rose(sync) |-> sync [*8] ##1 !sync;
  endproperty
  a_sync_len: assert property (p_sync_len) else $error("marker not one period");
  property p_sync_gap;
    $fell(sync) |-> ##56 $rose(sync);
  endproperty
  a_sync_gap: assert property (p_sync_gap) else $error("marker gap wrong");
  property p_single_driver;
    !(dev_oe && host_oe);
  endproperty
  a_single_driver: assert property (p_single_driver) else $error("bus driven twice");
  property p_dev_quiet;
    (tick_r >= 7'h04 && tick_r <= 7'h17) |-> !dev_oe;
  endproperty
  a_dev_quiet: assert property (p_dev_quiet) else $error("device drives in address time");
  property p_dev_window;
    $rose(dev_oe) |-> (tick_r >= 7'h18 && tick_r <= 7'h1f) || (tick_r >= 7'h30 && tick_r <= 7'h37);
  endproperty
  a_dev_window: assert property (p_dev_window) else $error("device drive starts late");
  property p_refuse;
    (tick_r == 7'h1c && !sel_r) |-> !dev_oe;
  endproperty
  a_refuse: assert property (p_refuse) else $error("unselected device drives");
  property p_word;
    (tick_r == 7'h1e && dev_oe) |-> data == exp_byte[7:4] ##8 data == exp_byte[3:0];
  endproperty
  a_word: assert property (p_word) else $error("fetched word wrong");
  c_fetch: cover property (tick_r == 7'h1e && dev_oe);
  c_port_read: cover property (tick_r == 7'h34 && dev_oe);
  c_refused: cover property (tick_r == 7'h1c && !sel_r);
endmodule : rom_io_chk

// ### mux_bus_rom_with_io_port_tb.sv
// testbench joining host and device ends with randomised bus traffic
module mux_bus_rom_with_io_port_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import rom_io_pkg::*;
  // ---------------------------------------------------------------
  // build options and expectations
  // ---------------------------------------------------------------
  localparam logic [3:0] ID = 4'h5;
  localparam logic [3:0] OUTS = 4'h6;
  localparam logic [3:0] INV = 4'ha;
  function automatic logic [7:0] rom_byte(input logic [7:0] n);
    return 8'(n * 37 + 27);
  endfunction : rom_byte
  function automatic logic [2047:0] rom_fill();
    logic [2047:0] img;
    img = '0;
    for (int n = 0; n < 256; n++) img[8*n +: 8] = rom_byte(8'(n));
    return img;
  endfunction : rom_fill
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next
  localparam logic [2047:0] IMG = rom_fill();
  logic clk_in, rst_n_in, cyc, stb, we, ack, clr;
  logic [3:0] adr, sel, pin_in, pin_out, pin_oe;
  logic [31:0] wdat, rdat, lfsr;
  int fails, checks_done, cycles;
  bus_link_if link_bus ();
  rom_io_host i_rom_io_host (.clk_in(clk_in), .rst_n_in(rst_n_in), .link(link_bus), .wb_cyc_in(cyc),
    .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat),
    .wb_dat_out(rdat), .wb_ack_out(ack));
  rom_io_device #(.CHIP_ID(ID), .PIN_IS_OUTPUT(OUTS), .PIN_INVERT(INV), .ROM_IMAGE(IMG)) i_rom_io_device (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .link(link_bus), .port_clear_in(clr), .port_pin_in(pin_in),
    .port_pin_out(pin_out), .port_pin_oe_out(pin_oe));
  rom_io_chk #(.CHIP_ID(ID), .ROM_IMAGE(IMG)) i_rom_io_chk (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .phi1(link_bus.phi1), .phi2(link_bus.phi2), .sync(link_bus.sync),
    .bank_command_line(link_bus.bank_command_line), .host_dout(link_bus.host_dout),
    .host_oe(link_bus.host_oe), .dev_dout(link_bus.dev_dout), .dev_oe(link_bus.dev_oe),
    .data(link_bus.data));
  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : final_report
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  // one classic cycle; the request stands until ack is sampled high
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_in);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'hf;
    wdat <= d;
    do begin
      @(posedge clk_in);
      n++;
    end while (ack !== 1'b1 && n < 100);
    q = rdat;
    if (n >= 100) fails++;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_in);
  endtask : wb
  task automatic run_cmd(input logic [1:0] k, input logic [3:0] c, input logic [3:0] pd, input logic [7:0] a,
                         output logic [31:0] st);
    int n;
    wb(1'b1, CMD_OFS, {14'h0, k, pd, c, a}, st);
    n = 0;
    do begin
      wb(1'b0, STATUS_OFS, 32'h0, st);
      n++;
    end while (st[STAT_BUSY_POS] !== 1'b0 && n < 200);
    if (n >= 200) fails++;
  endtask : run_cmd
  // ---------------------------------------------------------------
  // clock, timeout and main sequence
  // ---------------------------------------------------------------
  initial begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 40000) begin
      fails++;
      final_report();
    end
  end
  initial begin
    logic [31:0] st;
    logic [3:0] d;
    logic [7:0] a;
    {cyc, stb, we, clr, rst_n_in} = 5'h00;
    {adr, sel, pin_in} = 12'h000;
    wdat = 32'h0;
    lfsr = 32'h5958ae43;
    repeat (16) @(posedge clk_in);
    rst_n_in <= 1'b1;
    check(pin_out, INV & OUTS);
    check(pin_oe, OUTS);
    for (int i = 0; i < 12; i++) begin
      lfsr = lfsr_next(lfsr);
      a = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : lfsr[7:0];
      run_cmd(kind_fetch, ID, 4'h0, a, st);
      check(st[15:8], rom_byte(a));
    end
    run_cmd(kind_fetch, ID ^ 4'h3, 4'h0, 8'h10, st);
    check(st[15:8], 8'hff);
    for (int i = 0; i < 6; i++) begin
      lfsr = lfsr_next(lfsr);
      d = lfsr[11:8];
      pin_in <= lfsr[15:12];
      run_cmd(kind_send_reg, ID, 4'h0, 8'h00, st);
      run_cmd(kind_port_write, ID, d, 8'h00, st);
      check(pin_out, (d ^ INV) & OUTS);
      run_cmd(kind_port_read, ID, 4'h0, 8'h00, st);
      check(st[19:16], (lfsr[15:12] ^ INV) & ~OUTS);
      run_cmd(kind_send_reg, ID ^ 4'h1, 4'h0, 8'h00, st);
      run_cmd(kind_port_write, ID ^ 4'h1, ~d, 8'h00, st);
      check(pin_out, (d ^ INV) & OUTS);
    end
    run_cmd(kind_send_reg, ID, 4'h0, 8'h00, st);
    run_cmd(kind_port_write, ID, 4'hf, 8'h00, st);
    check(pin_out, (4'hf ^ INV) & OUTS);
    @(posedge clk_in);
    clr <= 1'b1;
    // clear acts without waiting for an edge
    #5;
    check(pin_out, INV & OUTS);
    @(posedge clk_in);
    clr <= 1'b0;
    repeat (4) @(posedge clk_in);
    check(pin_out, INV & OUTS);
    wb(1'b1, 4'hc, 32'hffffffff, st);
    wb(1'b0, 4'hc, 32'h0, st);
    check(st, 32'h0);
    final_report();
  end
endmodule : mux_bus_rom_with_io_port_tb
